// File: shared/sps_pkg.sv
// Shared constants for the alignment pulse synchroniser and its controller
package sps_pkg;
    // Resynchroniser depth on the asynchronous request path
    localparam int SYNC_STAGES_MIN = 2;
    // Length in clock cycles of the aligned pulse driven by the converter end
    localparam int ALIGN_PULSE_LEN = 4;
    // Length in clock cycles of a request or direct alignment pulse from the controller
    localparam int REQ_PULSE_LEN = 4;
    // Idle cycles between the two pulses of a double alignment
    localparam int REQ_PULSE_GAP = 16;
    // Settle cycles after the last pulse before the controller reports done
    localparam int REQ_SETTLE_LEN = 8;
    // Default sampling clock cycles per conversion result
    localparam int RESULT_DIV_DEF = 32;
    // Width of the alignment event counter
    localparam int ALIGN_CNT_W = 8;
    // Width of the timing counters
    localparam int TIMER_W = 8;
    // Idle level of all active-low strobes
    localparam logic STROBE_IDLE = 1'b1;
endpackage

// File: shared/sps_if.sv
// Link between the converter end and its controller
`timescale 1ns/10ps
interface sps_if;
    logic start_n;          // Asynchronous alignment request, active low
    logic sync_out_n;       // Aligned pulse from converter, active low
    logic direct_n;         // Direct alignment pulse from controller, active low
    logic direct_oe;        // Controller drives the alignment input directly
    logic sync_in_n;        // Alignment input of the converter, active low
    logic new_result_flag;  // One-cycle pulse per conversion result

    // Loopback of the aligned pulse unless the controller drives the input itself
    assign sync_in_n = direct_oe ? direct_n : sync_out_n;

    modport dev (
        input  start_n,
        input  sync_in_n,
        output sync_out_n,
        output new_result_flag
    );

    modport host (
        output start_n,
        output direct_n,
        output direct_oe,
        input  sync_out_n,
        input  new_result_flag
    );
endinterface

// File: src/sps_device.sv
// Converter end: request resynchroniser, aligned pulse generator and sample phase
//
// Overview of operation
// - Direct alignment pulses must be clock-synchronous.
// - Daisy chains need two successive alignment pulses.
// - Shared clock, one flag watched: two pulses.
// - Request input is treated as asynchronous.
// - Request sampled first, then aligned pulse driven.
// - Aligned pulse changes only on sampling clock.
// - Aligned pulse only when request input used.
// - Unused request input held at logic high.
// - Direct alignment makes request and pulse unused.
// - Aligned pulse loops back to all alignment inputs.
// - Alignment pulse restarts the sampling phase.
`timescale 1ns/10ps
module sps_device #(
    parameter int SYNC_STAGES = sps_pkg::SYNC_STAGES_MIN,
    parameter int RESULT_DIV  = sps_pkg::RESULT_DIV_DEF
) (
    // Clock and reset
    input  wire logic                            sys_clk_i,
    input  wire logic                            sys_rst_i,
    // Link
    sps_if.dev                                   link,
    // User side
    output logic                                 result_strobe_o,
    output logic                                 aligned_o,
    output logic                                 realigned_o,
    output logic [sps_pkg::ALIGN_CNT_W-1:0]      align_count_o,
    output logic [$clog2(RESULT_DIV)-1:0]        phase_o
);
    import sps_pkg::*;

    localparam int PW = $clog2(RESULT_DIV);
    localparam logic [PW-1:0] PHASE_LAST = PW'(RESULT_DIV - 1);
    localparam logic [TIMER_W-1:0] PULSE_LAST = TIMER_W'(ALIGN_PULSE_LEN - 1);

    generate
        if (SYNC_STAGES < SYNC_STAGES_MIN) begin : g_chk_stages
            $error("sps_device: SYNC_STAGES must be at least 2");
        end
        if (RESULT_DIV < 2 || RESULT_DIV > 256) begin : g_chk_div
            $error("sps_device: RESULT_DIV must be 2 to 256");
        end
        if (ALIGN_PULSE_LEN < 1 || ALIGN_PULSE_LEN > (1 << TIMER_W)) begin : g_chk_pulse
            $error("sps_device: ALIGN_PULSE_LEN does not fit the pulse timer");
        end
    endgenerate

    typedef struct packed {
        logic [SYNC_STAGES-1:0] req_sync;
        logic                   req_prev;
        logic                   pulse_act;
        logic [TIMER_W-1:0]     pulse_cnt;
        logic                   sync_out_n;
        logic                   align_prev;
        logic [PW-1:0]          phase;
        logic                   result;
        logic                   aligned;
        logic                   realigned;
        logic [ALIGN_CNT_W-1:0] align_cnt;
    } sps_dev_s;

    sps_dev_s st_q;
    sps_dev_s st_d;

    logic req_level;
    logic req_fall;
    logic align_fall;

    // Last stage of the resynchroniser; only it feeds the edge detector
    assign req_level  = st_q.req_sync[SYNC_STAGES-1];
    assign req_fall   = st_q.req_prev & ~req_level;
    // Alignment input is already in this clock domain, so no extra stages
    assign align_fall = st_q.align_prev & ~link.sync_in_n;

    always_comb begin
        st_d = st_q;

        // Request has no timing relation to this clock
        st_d.req_sync = {st_q.req_sync[SYNC_STAGES-2:0], link.start_n};
        st_d.req_prev = req_level;

        // A request held high never fires, so the pulse stays idle when unused
        if (st_q.pulse_act) begin
            if (st_q.pulse_cnt == PULSE_LAST) begin
                st_d.pulse_act  = 1'b0;
                st_d.sync_out_n = STROBE_IDLE;
                st_d.pulse_cnt  = '0;
            end else begin
                st_d.pulse_cnt = st_q.pulse_cnt + TIMER_W'(1);
            end
        end else if (req_fall) begin
            // Requests during a running pulse merge into it
            st_d.pulse_act  = 1'b1;
            st_d.sync_out_n = ~STROBE_IDLE;
            st_d.pulse_cnt  = '0;
        end

        // Sample phase and result strobe
        st_d.align_prev = link.sync_in_n;
        st_d.result     = 1'b0;
        st_d.realigned  = 1'b0;
        if (align_fall) begin
            // A pulse away from phase zero means this end was out of step
            st_d.realigned = st_q.aligned && (st_q.phase != '0);
            st_d.phase     = '0;
            st_d.aligned   = 1'b1;
            st_d.align_cnt = st_q.align_cnt + ALIGN_CNT_W'(1);
        end else if (st_q.phase == PHASE_LAST) begin
            st_d.phase  = '0;
            st_d.result = st_q.aligned;
        end else begin
            st_d.phase = st_q.phase + PW'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q.req_sync   <= {SYNC_STAGES{STROBE_IDLE}};
            st_q.req_prev   <= STROBE_IDLE;
            st_q.pulse_act  <= 1'b0;
            st_q.pulse_cnt  <= '0;
            st_q.sync_out_n <= STROBE_IDLE;
            st_q.align_prev <= STROBE_IDLE;
            st_q.phase      <= '0;
            st_q.result     <= 1'b0;
            st_q.aligned    <= 1'b0;
            st_q.realigned  <= 1'b0;
            st_q.align_cnt  <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.sync_out_n      = st_q.sync_out_n;
    assign link.new_result_flag = st_q.result;
    assign result_strobe_o      = st_q.result;
    assign aligned_o            = st_q.aligned;
    assign realigned_o          = st_q.realigned;
    assign align_count_o        = st_q.align_cnt;
    assign phase_o              = st_q.phase;
endmodule

// File: src/sps_host.sv
// Controller end: issues single or double alignment pulses by request or directly
`timescale 1ns/10ps
module sps_host (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    // Link
    sps_if.host       link,
    // User side
    input  wire logic align_req_i,
    input  wire logic double_i,
    input  wire logic direct_mode_i,
    output logic      busy_o,
    output logic      done_o,
    output logic      result_seen_o
);
    import sps_pkg::*;

    localparam logic [TIMER_W-1:0] LOW_LAST    = TIMER_W'(REQ_PULSE_LEN - 1);
    localparam logic [TIMER_W-1:0] GAP_LAST    = TIMER_W'(REQ_PULSE_GAP - 1);
    localparam logic [TIMER_W-1:0] SETTLE_LAST = TIMER_W'(REQ_SETTLE_LEN - 1);

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_LOW1,
        HS_GAP,
        HS_LOW2,
        HS_SETTLE
    } sps_hstate_e;

    typedef struct packed {
        sps_hstate_e        state;
        logic [TIMER_W-1:0] cnt;
        logic               twice;
        logic               direct;
        logic               start_n;
        logic               direct_n;
        logic               busy;
        logic               done;
        logic               seen;
    } sps_host_s;

    sps_host_s st_q;
    sps_host_s st_d;

    logic low_now;

    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        st_d.cnt  = st_q.cnt + TIMER_W'(1);
        unique case (st_q.state)
            HS_IDLE: begin
                st_d.cnt = '0;
                if (align_req_i) begin
                    st_d.state  = HS_LOW1;
                    st_d.twice  = double_i;
                    st_d.direct = direct_mode_i;
                    st_d.seen   = 1'b0;
                end
            end
            HS_LOW1: begin
                if (st_q.cnt == LOW_LAST) begin
                    st_d.cnt   = '0;
                    st_d.state = st_q.twice ? HS_GAP : HS_SETTLE;
                end
            end
            HS_GAP: begin
                if (st_q.cnt == GAP_LAST) begin
                    st_d.cnt   = '0;
                    st_d.state = HS_LOW2;
                end
            end
            HS_LOW2: begin
                if (st_q.cnt == LOW_LAST) begin
                    st_d.cnt   = '0;
                    st_d.state = HS_SETTLE;
                end
            end
            HS_SETTLE: begin
                if (st_q.cnt == SETTLE_LAST) begin
                    st_d.cnt   = '0;
                    st_d.state = HS_IDLE;
                    st_d.done  = 1'b1;
                end
            end
        endcase
        // Set wins over the clear of a request taken in the same cycle
        if (link.new_result_flag && (st_q.state == HS_IDLE)) begin
            st_d.seen = 1'b1;
        end
        st_d.busy = (st_d.state != HS_IDLE);
        low_now   = (st_d.state == HS_LOW1) || (st_d.state == HS_LOW2);
        // Request line idles high whenever it is not pulsing
        st_d.start_n  = ~(low_now && !st_d.direct);
        // Direct drive is a registered, clock-synchronous strobe
        st_d.direct_n = ~(low_now && st_d.direct);
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q.state    <= HS_IDLE;
            st_q.cnt      <= '0;
            st_q.twice    <= 1'b0;
            st_q.direct   <= 1'b0;
            st_q.start_n  <= STROBE_IDLE;
            st_q.direct_n <= STROBE_IDLE;
            st_q.busy     <= 1'b0;
            st_q.done     <= 1'b0;
            st_q.seen     <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.start_n   = st_q.start_n;
    assign link.direct_n  = st_q.direct_n;
    assign link.direct_oe = st_q.direct;
    assign busy_o         = st_q.busy;
    assign done_o         = st_q.done;
    assign result_seen_o  = st_q.seen;
endmodule

// File: test/sps_monitor.sv
// Concurrent checks on the link between the controller and converter ends
`timescale 1ns/10ps
module sps_monitor #(
    parameter int RESULT_DIV = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Link signals
    input wire logic start_n,
    input wire logic sync_out_n,
    input wire logic direct_n,
    input wire logic direct_oe,
    input wire logic sync_in_n,
    input wire logic new_result_flag
);
    localparam int RES_LO = RESULT_DIV - 1;
    localparam int RES_HI = RESULT_DIV + 1;
    logic seen_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Remembers any alignment since reset
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seen_q <= 1'b0;
        end else if (!sync_in_n) begin
            seen_q <= 1'b1;
        end
    end

    a_sample_first: assert property (
        $fell(sync_out_n) |-> !$past(start_n, 3) && $past(start_n, 4)) else $error("aligned pulse without request");
    a_pulse_length: assert property (
        $fell(sync_out_n) |-> (!sync_out_n)[*4] ##1 sync_out_n) else $error("aligned pulse length");
    a_request_answered: assert property (
        $fell(start_n) |-> ##3 $fell(sync_out_n)) else $error("request not answered in three cycles");
    a_direct_quiet: assert property (
        direct_oe |-> sync_out_n) else $error("aligned pulse in direct mode");
    a_loop_back: assert property (
        !direct_oe |-> sync_in_n == sync_out_n) else $error("loopback broken");
    a_no_early_result: assert property (
        new_result_flag |-> seen_q) else $error("result before alignment");
    a_result_after_align: assert property (
        $fell(sync_in_n) |-> ##[RES_LO:RES_HI] new_result_flag) else $error("no result after alignment");
    a_result_period: assert property (
        new_result_flag ##1 sync_in_n[*3] |-> ##1 new_result_flag) else $error("result period");

    c_request: cover property ($fell(sync_out_n));
    c_direct: cover property ($fell(direct_n));
    c_result: cover property (new_result_flag);
endmodule

// File: test/sps_tb.sv
// Self-checking bench for the controller and converter ends joined by the link
`timescale 1ns/10ps
module sps_tb;
    import sps_pkg::*;
    localparam int RDIV = 4;
    logic                   sys_clk_i     = 1'b0;
    logic                   sys_rst_i     = 1'b1;
    logic                   align_req_i   = 1'b0;
    logic                   double_i      = 1'b0;
    logic                   direct_mode_i = 1'b0;
    logic                   busy_o, done_o, result_seen_o, result_strobe_o, aligned_o, realigned_o;
    logic [ALIGN_CNT_W-1:0] align_count_o;
    logic [1:0]             phase_o;
    logic [7:0]             n_align       = 8'h00;
    int                     n_mismatch    = 0;
    int                     comparisons   = 0;
    int                     tick          = 0;

    sps_if link ();
    sps_device #(.RESULT_DIV(RDIV)) i_sps_device (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link),
        .result_strobe_o(result_strobe_o), .aligned_o(aligned_o), .realigned_o(realigned_o),
        .align_count_o(align_count_o), .phase_o(phase_o));
    sps_host i_sps_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link), .align_req_i(align_req_i),
        .double_i(double_i), .direct_mode_i(direct_mode_i), .busy_o(busy_o), .done_o(done_o),
        .result_seen_o(result_seen_o));
    sps_monitor #(.RESULT_DIV(RDIV)) i_sps_monitor (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .start_n(link.start_n), .sync_out_n(link.sync_out_n), .direct_n(link.direct_n),
        .direct_oe(link.direct_oe), .sync_in_n(link.sync_in_n), .new_result_flag(link.new_result_flag));

    always #2 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Long idle after reset must stay silent
    task automatic idle_quiet;
        logic [15:0] res;
        res = 16'h0000;
        repeat (20) begin
            @(negedge sys_clk_i);
            res += 16'(result_strobe_o);
        end
        chk(res, 16'h0000, "results before alignment");
        chk(16'(aligned_o), 16'h0000, "aligned before alignment");
        chk(16'(link.sync_out_n), 16'h0001, "aligned pulse idle");
    endtask

    // One sequence; a second request while busy must be ignored
    task automatic do_align(input logic dbl, input logic dir, input logic [15:0] cyc_e, input logic [15:0] out_e,
                            input logic [15:0] rea_e);
        logic [15:0] cyc, lows, outs, res, rea, bsy;
        cyc = 16'h0000;
        lows = 16'h0000;
        outs = 16'h0000;
        res = 16'h0000;
        rea = 16'h0000;
        bsy = 16'h0000;
        @(posedge sys_clk_i);
        align_req_i   <= 1'b1;
        double_i      <= dbl;
        direct_mode_i <= dir;
        @(posedge sys_clk_i);
        align_req_i <= 1'b0;
        do begin
            @(negedge sys_clk_i);
            cyc++;
            lows += 16'(dir ? !link.direct_n : !link.start_n);
            outs += 16'(!link.sync_out_n);
            rea += 16'(realigned_o);
            bsy += 16'(busy_o);
            if (done_o !== 1'b1) begin
                @(posedge sys_clk_i);
                align_req_i <= (cyc == 16'h0002);
            end
        end while (done_o !== 1'b1 && cyc < 16'h0064);
        n_align = n_align + (dbl ? 8'h02 : 8'h01);
        chk(cyc, cyc_e, "cycles to done");
        chk(lows, dbl ? 16'h0008 : 16'h0004, "strobe low cycles");
        chk(outs, out_e, "aligned pulse cycles");
        chk(16'(align_count_o), 16'(n_align), "alignment count");
        chk(16'(aligned_o), 16'h0001, "aligned flag");
        chk(bsy, cyc_e - 16'h0001, "busy cycles");
        chk(rea, rea_e, "out of step alignments");
        // Direct pulses align three cycles earlier than the resynchronised path
        chk(16'(phase_o), dir ? 16'h0003 : 16'h0000, "phase at done");
        repeat (8) begin
            @(negedge sys_clk_i);
            res += 16'(result_strobe_o);
        end
        chk(res, 16'h0002, "results in eight cycles");
        chk(16'(result_seen_o), 16'h0001, "result seen");
    endtask

    task automatic single_request;
        do_align(1'b0, 1'b0, 16'h000D, 16'h0004, 16'h0000);
    endtask

    task automatic double_request;
        do_align(1'b1, 1'b0, 16'h0021, 16'h0008, 16'h0002);
    endtask

    // Direct pulses bypass the resynchroniser, so no aligned pulse appears
    task automatic single_direct;
        do_align(1'b0, 1'b1, 16'h000D, 16'h0000, 16'h0001);
    endtask

    task automatic double_direct;
        do_align(1'b1, 1'b1, 16'h0021, 16'h0000, 16'h0002);
    endtask

    // Whole run needs under 200 cycles
    always @(posedge sys_clk_i) begin
        tick++;
        if (tick == 500) begin
            n_mismatch++;
            $display("wrong value at %0t: run limit reached", $time);
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        idle_quiet();
        single_request();
        double_request();
        single_direct();
        double_direct();
        single_request();
        print_verdict();
    end
endmodule
